// ### adsq_map.vh
`ifndef ADSQ_MAP_VH
`define ADSQ_MAP_VH

// register indices; the byte address on the bus is four times the index
`define ADSQ_IDX_CTRLA   5'h00
`define ADSQ_IDX_ACCUM   5'h01
`define ADSQ_IDX_CLKREF  5'h02
`define ADSQ_IDX_DELAY   5'h03
`define ADSQ_IDX_WINMODE 5'h04
`define ADSQ_IDX_SAMPLE_LENGTH 5'h05
`define ADSQ_IDX_INSEL   5'h06
`define ADSQ_IDX_TRIG    5'h08
`define ADSQ_IDX_EVENT_START_CONTROL  5'h09
`define ADSQ_IDX_IRQEN   5'h0a
`define ADSQ_IDX_IRQSTAT 5'h0b
`define ADSQ_IDX_RESULT  5'h10
`define ADSQ_IDX_LOWTHR  5'h12
`define ADSQ_IDX_HIGHTHR 5'h14

// writable bit masks, reset value shared by all registers
`define ADSQ_MASK_CTRLA   8'h87
`define ADSQ_MASK_ACCUM   8'h07
`define ADSQ_MASK_CLKREF  8'h77
`define ADSQ_MASK_WINMODE 8'h07
`define ADSQ_MASK_SAMPLE_LENGTH 8'h1f
`define ADSQ_MASK_INSEL   8'h1f
`define ADSQ_MASK_ONE     8'h01
`define ADSQ_MASK_TWO     8'h03
`define ADSQ_RESET_VAL    8'h00

// field positions
`define ADSQ_BIT_ENABLE   0
`define ADSQ_BIT_CONTIN   1
`define ADSQ_BIT_RESSEL   2
`define ADSQ_BIT_VARY     4
`define ADSQ_BIT_RESULT_READY   0
`define ADSQ_BIT_WMATCH   1

// window modes
`define ADSQ_WIN_NONE    3'h0
`define ADSQ_WIN_BELOW   3'h1
`define ADSQ_WIN_ABOVE   3'h2
`define ADSQ_WIN_INSIDE  3'h3
`define ADSQ_WIN_OUTSIDE 3'h4

// timing counts in converter-clock cycles, and the highest valid startup-delay code
`define ADSQ_BASE_SAMPLE 9'h002
`define ADSQ_CONV_CYCLES 9'h00b
`define ADSQ_INIT_MAXSEL 3'h5

`endif

// ### adsq_sequencer.v
`timescale 1ns/1ps
`include "adsq_map.vh"

module adsq_sequencer #(
  parameter [8:0] CONV_CYCLES = `ADSQ_CONV_CYCLES
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        startEvent,
  input  wire        deepSleepWake,
  input  wire [9:0]  coreSample,
  output reg         sampleOpen,
  output reg         convRun,
  output reg  [4:0]  inputSelActive,
  output reg         irq
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_INIT = 3'd1;
  localparam [2:0] S_SDLY = 3'd2;
  localparam [2:0] S_SAMP = 3'd3;
  localparam [2:0] S_CONV = 3'd4;

  // software registers
  reg [7:0]  ctrlA_r;
  reg [7:0]  accumCtl_r;
  reg [7:0]  clkRef_r;
  reg [7:0]  delayCtl_r;
  reg [7:0]  winModeCtl_r;
  reg [7:0]  sampLenCtl_r;
  reg [7:0]  inputSel_r;
  reg [7:0]  evCtl_r;
  reg [7:0]  irqEn_r;
  reg [7:0]  irqStat_r;
  reg [15:0] lowThr_r;
  reg [15:0] highThr_r;
  reg [15:0] result_r;
  // bus data phase
  reg        wrPend_r;
  reg [4:0]  wrIdx_r;
  // sequencer
  reg [2:0]  state_r;
  reg [8:0]  cnt_r;
  reg [7:0]  divCnt_r;
  reg        tick_r;
  reg        initPend_r;
  reg [15:0] accum_r;
  reg [6:0]  sampCnt_r;
  // event and wake synchronisers
  reg [2:0]  evSync_r;
  reg        evLevel_r;
  reg [2:0]  wakeSync_r;
  reg        wakeLevel_r;

  wire        addrTaken = hsel & htrans[1] & hready;
  wire [4:0]  addrIdx   = haddr[6:2];
  wire        busy      = (state_r != S_IDLE);
  wire [7:0]  wData     = hwdata[7:0];
  wire        wrTrig    = wrPend_r & (wrIdx_r == `ADSQ_IDX_TRIG);
  wire        enabled   = ctrlA_r[`ADSQ_BIT_ENABLE];
  wire        evRise    = (evSync_r[1] == evSync_r[2]) & evSync_r[2] & ~evLevel_r;
  wire        wakeRise  = (wakeSync_r[1] == wakeSync_r[2]) & wakeSync_r[2] & ~wakeLevel_r;
  wire        swStart   = wrTrig & wData[0];
  wire        swAbort   = wrTrig & ~wData[0] & busy;
  wire        evStart   = evRise & evCtl_r[0];
  wire        go        = enabled & ~busy & (swStart | evStart);
  wire [9:0]  sampVal   = ctrlA_r[`ADSQ_BIT_RESSEL] ? {2'b00, coreSample[9:2]} : coreSample;
  wire [15:0] sumVal    = accum_r + {6'h00, sampVal};
  wire        lastSamp  = (sampCnt_r == (sampNeed(accumCtl_r[2:0]) - 7'h01));
  wire        convDone  = (state_r == S_CONV) & tick_r & (cnt_r == 9'h000) & lastSamp;
  wire        resRead   = addrTaken & ~hwrite & (addrIdx == `ADSQ_IDX_RESULT);

  // startup delay in converter cycles; reserved codes give none
  function [8:0] initCycles;
    input [2:0] sel;
    begin
      if (sel == 3'h0 || sel > `ADSQ_INIT_MAXSEL) begin
        initCycles = 9'h000;
      end else begin
        initCycles = 9'h008 << sel;
      end
    end
  endfunction

  // samples summed per conversion; reserved code behaves as one
  function [6:0] sampNeed;
    input [2:0] code;
    begin
      if (code == 3'h7) begin
        sampNeed = 7'h01;
      end else begin
        sampNeed = 7'h01 << code;
      end
    end
  endfunction

  // window condition on the accumulated result
  function winHit;
    input [2:0]  mode;
    input [15:0] res;
    input [15:0] lo;
    input [15:0] hi;
    begin
      case (mode)
        `ADSQ_WIN_BELOW:   winHit = (res < lo);
        `ADSQ_WIN_ABOVE:   winHit = (res > hi);
        `ADSQ_WIN_INSIDE:  winHit = (res > lo) && (res < hi);
        `ADSQ_WIN_OUTSIDE: winHit = (res < lo) || (res > hi);
        default:           winHit = 1'b0;
      endcase
    end
  endfunction

  // read mux for the register file; unmapped words read zero
  function [15:0] readReg;
    input [4:0] idx;
    begin
      if (idx == `ADSQ_IDX_CTRLA) begin
        readReg = {8'h00, ctrlA_r};
      end else if (idx == `ADSQ_IDX_ACCUM) begin
        readReg = {8'h00, accumCtl_r};
      end else if (idx == `ADSQ_IDX_CLKREF) begin
        readReg = {8'h00, clkRef_r};
      end else if (idx == `ADSQ_IDX_DELAY) begin
        readReg = {8'h00, delayCtl_r};
      end else if (idx == `ADSQ_IDX_WINMODE) begin
        readReg = {8'h00, winModeCtl_r};
      end else if (idx == `ADSQ_IDX_SAMPLE_LENGTH) begin
        readReg = {8'h00, sampLenCtl_r};
      end else if (idx == `ADSQ_IDX_INSEL) begin
        readReg = {8'h00, inputSel_r};
      end else if (idx == `ADSQ_IDX_TRIG) begin
        readReg = {15'h0000, busy};
      end else if (idx == `ADSQ_IDX_EVENT_START_CONTROL) begin
        readReg = {8'h00, evCtl_r};
      end else if (idx == `ADSQ_IDX_IRQEN) begin
        readReg = {8'h00, irqEn_r};
      end else if (idx == `ADSQ_IDX_IRQSTAT) begin
        readReg = {8'h00, irqStat_r};
      end else if (idx == `ADSQ_IDX_RESULT) begin
        readReg = result_r;
      end else if (idx == `ADSQ_IDX_LOWTHR) begin
        readReg = lowThr_r;
      end else if (idx == `ADSQ_IDX_HIGHTHR) begin
        readReg = highThr_r;
      end else begin
        readReg = 16'h0000;
      end
    end
  endfunction

  // bus slave: zero wait states, read data registered in the address phase
  always @(posedge core_clk) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wrPend_r  <= 1'b0;
      wrIdx_r   <= 5'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_r  <= addrTaken & hwrite;
      wrIdx_r   <= addrIdx;
      if (addrTaken & ~hwrite) begin
        hrdata <= {16'h0000, readReg(addrIdx)};
      end
    end
  end

  // pin inputs pass three flops; a level counts once the last two agree
  always @(posedge core_clk) begin
    if (rst) begin
      evSync_r    <= 3'b000;
      evLevel_r   <= 1'b0;
      wakeSync_r  <= 3'b000;
      wakeLevel_r <= 1'b0;
    end else begin
      evSync_r   <= {evSync_r[1:0], startEvent};
      wakeSync_r <= {wakeSync_r[1:0], deepSleepWake};
      if (evSync_r[1] == evSync_r[2]) begin
        evLevel_r <= evSync_r[2];
      end
      if (wakeSync_r[1] == wakeSync_r[2]) begin
        wakeLevel_r <= wakeSync_r[2];
      end
    end
  end

  // converter clock as a one-cycle tick every 2^(code+1) peripheral cycles
  always @(posedge core_clk) begin
    if (rst) begin
      divCnt_r <= 8'h00;
      tick_r   <= 1'b0;
    end else if (go) begin
      divCnt_r <= 8'h01;  // restart so the first phase gets whole converter cycles
      tick_r   <= 1'b0;
    end else if (divCnt_r >= (8'hff >> (3'h7 - clkRef_r[2:0]))) begin
      divCnt_r <= 8'h00;
      tick_r   <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 8'h01;
      tick_r   <= 1'b0;
    end
  end

  // configuration writes in the data phase; sampling delay also steps itself
  always @(posedge core_clk) begin
    if (rst) begin
      ctrlA_r      <= `ADSQ_RESET_VAL;
      accumCtl_r   <= `ADSQ_RESET_VAL;
      clkRef_r     <= `ADSQ_RESET_VAL;
      delayCtl_r   <= `ADSQ_RESET_VAL;
      winModeCtl_r <= `ADSQ_RESET_VAL;
      sampLenCtl_r <= `ADSQ_RESET_VAL;
      inputSel_r   <= `ADSQ_RESET_VAL;
      evCtl_r      <= `ADSQ_RESET_VAL;
      irqEn_r      <= `ADSQ_RESET_VAL;
      lowThr_r     <= 16'h0000;
      highThr_r    <= 16'h0000;
    end else begin
      if (state_r == S_SAMP && tick_r && cnt_r == 9'h000 && delayCtl_r[`ADSQ_BIT_VARY]) begin
        delayCtl_r[3:0] <= delayCtl_r[3:0] + 4'h1;  // wraps in four bits
      end
      if (wrPend_r) begin
        if (wrIdx_r == `ADSQ_IDX_CTRLA) begin
          ctrlA_r <= wData & `ADSQ_MASK_CTRLA;
        end else if (wrIdx_r == `ADSQ_IDX_ACCUM) begin
          accumCtl_r <= wData & `ADSQ_MASK_ACCUM;
        end else if (wrIdx_r == `ADSQ_IDX_CLKREF) begin
          clkRef_r <= wData & `ADSQ_MASK_CLKREF;
        end else if (wrIdx_r == `ADSQ_IDX_DELAY) begin
          delayCtl_r <= wData;  // software value wins over the auto step
        end else if (wrIdx_r == `ADSQ_IDX_WINMODE) begin
          winModeCtl_r <= wData & `ADSQ_MASK_WINMODE;
        end else if (wrIdx_r == `ADSQ_IDX_SAMPLE_LENGTH) begin
          sampLenCtl_r <= wData & `ADSQ_MASK_SAMPLE_LENGTH;
        end else if (wrIdx_r == `ADSQ_IDX_INSEL) begin
          inputSel_r <= wData & `ADSQ_MASK_INSEL;
        end else if (wrIdx_r == `ADSQ_IDX_EVENT_START_CONTROL) begin
          evCtl_r <= wData & `ADSQ_MASK_ONE;
        end else if (wrIdx_r == `ADSQ_IDX_IRQEN) begin
          irqEn_r <= wData & `ADSQ_MASK_TWO;
        end else if (wrIdx_r == `ADSQ_IDX_LOWTHR) begin
          lowThr_r <= hwdata[15:0];
        end else if (wrIdx_r == `ADSQ_IDX_HIGHTHR) begin
          highThr_r <= hwdata[15:0];
        end
      end
    end
  end

  // startup delay becomes due on enable, switch to internal reference, or wake
  always @(posedge core_clk) begin
    if (rst) begin
      initPend_r <= 1'b0;
    end else if (wrPend_r && wrIdx_r == `ADSQ_IDX_CTRLA && wData[0] && !enabled) begin
      initPend_r <= 1'b1;
    end else if (wrPend_r && wrIdx_r == `ADSQ_IDX_CLKREF && wData[5:4] == 2'b00
                 && clkRef_r[5:4] != 2'b00) begin
      initPend_r <= 1'b1;
    end else if (wakeRise) begin
      initPend_r <= 1'b1;
    end else if (go || state_r == S_INIT) begin
      initPend_r <= 1'b0;  // consumed by the next start, even with a zero delay code
    end
  end

  // interrupt flags: hardware set wins over a clear in the same cycle
  always @(posedge core_clk) begin
    if (rst) begin
      irqStat_r <= `ADSQ_RESET_VAL;
    end else begin
      irqStat_r[`ADSQ_BIT_RESULT_READY] <= convDone
        | (irqStat_r[`ADSQ_BIT_RESULT_READY] & ~resRead
           & ~(wrPend_r & wrIdx_r == `ADSQ_IDX_IRQSTAT & wData[`ADSQ_BIT_RESULT_READY]));
      irqStat_r[`ADSQ_BIT_WMATCH] <= (convDone & winHit(winModeCtl_r[2:0], sumVal, lowThr_r, highThr_r))
        | (irqStat_r[`ADSQ_BIT_WMATCH] & ~resRead
           & ~(wrPend_r & wrIdx_r == `ADSQ_IDX_IRQSTAT & wData[`ADSQ_BIT_WMATCH]));
    end
  end

  // interrupt request from flag and enable
  always @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_r[1:0] & irqEn_r[1:0]);
    end
  end

  // conversion sequencer, counting converter-clock ticks
  always @(posedge core_clk) begin
    if (rst) begin
      state_r        <= S_IDLE;
      cnt_r          <= 9'h000;
      accum_r        <= 16'h0000;
      sampCnt_r      <= 7'h00;
      result_r       <= 16'h0000;
      inputSelActive <= 5'h00;
    end else if (swAbort || !enabled) begin
      state_r   <= S_IDLE;  // disabling stops it too
      accum_r   <= 16'h0000;
      sampCnt_r <= 7'h00;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (go) begin
            accum_r        <= 16'h0000;
            sampCnt_r      <= 7'h00;
            inputSelActive <= inputSel_r[4:0];  // latched per conversion
            if (initPend_r && initCycles(delayCtl_r[7:5]) != 9'h000) begin
              state_r <= S_INIT;
              cnt_r   <= initCycles(delayCtl_r[7:5]) - 9'h001;
            end else begin
              state_r <= S_SAMP;
              cnt_r   <= `ADSQ_BASE_SAMPLE + {4'h0, sampLenCtl_r[4:0]} - 9'h001;
            end
          end
        end
        S_INIT: begin
          if (tick_r) begin
            if (cnt_r == 9'h000) begin
              state_r <= S_SAMP;
              cnt_r   <= `ADSQ_BASE_SAMPLE + {4'h0, sampLenCtl_r[4:0]} - 9'h001;
            end else begin
              cnt_r <= cnt_r - 9'h001;
            end
          end
        end
        S_SDLY: begin
          if (tick_r) begin
            if (cnt_r == 9'h000) begin
              state_r <= S_SAMP;
              cnt_r   <= `ADSQ_BASE_SAMPLE + {4'h0, sampLenCtl_r[4:0]} - 9'h001;
            end else begin
              cnt_r <= cnt_r - 9'h001;
            end
          end
        end
        S_SAMP: begin
          if (tick_r) begin
            if (cnt_r == 9'h000) begin
              state_r <= S_CONV;
              cnt_r   <= CONV_CYCLES - 9'h001;
            end else begin
              cnt_r <= cnt_r - 9'h001;
            end
          end
        end
        S_CONV: begin
          if (tick_r) begin
            if (cnt_r != 9'h000) begin
              cnt_r <= cnt_r - 9'h001;
            end else begin
              if (lastSamp) begin
                result_r  <= sumVal;
                accum_r   <= 16'h0000;
                sampCnt_r <= 7'h00;
                inputSelActive <= inputSel_r[4:0];
              end else begin
                accum_r   <= sumVal;
                sampCnt_r <= sampCnt_r + 7'h01;
              end
              if (lastSamp && !ctrlA_r[`ADSQ_BIT_CONTIN]) begin
                state_r <= S_IDLE;  // start bit drops here
              end else if (delayCtl_r[3:0] != 4'h0) begin
                state_r <= S_SDLY;
                cnt_r   <= {5'h00, delayCtl_r[3:0]} - 9'h001;
              end else begin
                state_r <= S_SAMP;
                cnt_r   <= `ADSQ_BASE_SAMPLE + {4'h0, sampLenCtl_r[4:0]} - 9'h001;
              end
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // analog-side controls: capacitor open in delay and sampling, core converting
  always @(posedge core_clk) begin
    if (rst) begin
      sampleOpen <= 1'b0;
      convRun    <= 1'b0;
    end else begin
      sampleOpen <= (state_r == S_SDLY) | (state_r == S_SAMP);
      convRun    <= (state_r == S_CONV);
    end
  end

endmodule

// ### adsq_sequencer_chk.sv
`timescale 1ns/1ps
module adsq_seq_chk #(
  parameter [8:0] CONV_CYCLES = 9'h00b
) (
  input wire       core_clk,
  input wire       rst,
  input wire       hsel,
  input wire [1:0] htrans,
  input wire       hreadyout,
  input wire       hresp,
  input wire       sampleOpen,
  input wire       convRun,
  input wire [4:0] inputSelActive,
  input wire       irq
);
  localparam int TICK = 2; // bench keeps the divider at its reset code, two clocks a tick
  wire taken = hsel && htrans[1];
  reg [9:0] runLen_r;

  // length of the current conversion phase; only meaningful when it ends normally
  always @(posedge core_clk) begin
    if (rst || !convRun) runLen_r <= 10'h000;
    else runLen_r <= runLen_r + 10'h001;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_bus_zero_wait: assert property (!$past(rst) |-> hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  a_conv_after_sample: assert property ($rose(convRun) |-> $past(sampleOpen))
    else $error("conversion phase started without a sampling phase");
  a_conv_length: assert property ($fell(convRun) |-> runLen_r == CONV_CYCLES * TICK)
    else $error("conversion phase length wrong");
  a_sample_min: assert property ($rose(sampleOpen) |-> sampleOpen [*4])
    else $error("sampling phase shorter than two ticks");
  a_cap_not_conv: assert property (!(sampleOpen && convRun))
    else $error("capacitor open during conversion");
  a_sel_held: assert property (($past(convRun) && convRun) ##1 convRun
                               |-> $past(inputSelActive, 2) == $past(inputSelActive))
    else $error("input selection changed during conversion");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(convRun) || $past(convRun, 2)
                                     || $past(taken, 2) || $past(taken, 3))
    else $error("interrupt raised without completion or enable write");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(taken, 2) || $past(taken, 3))
    else $error("interrupt dropped without a bus access");
endmodule

bind adsq_sequencer adsq_seq_chk #(.CONV_CYCLES(CONV_CYCLES)) chk_i (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hreadyout(hreadyout),
  .hresp(hresp), .sampleOpen(sampleOpen), .convRun(convRun), .inputSelActive(inputSelActive), .irq(irq)
);

// ### test_adsq_sequencer.sv
`timescale 1ns/1ps
`include "adsq_map.vh"
module test_adsq_sequencer;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0000_0000;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] hwdata = 32'h0000_0000;
  reg         startEvent = 1'b0;
  reg         deepSleepWake = 1'b0;
  reg  [9:0]  coreSample = 10'h150;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        sampleOpen;
  wire        convRun;
  wire [4:0]  inputSelActive;
  wire        irq;
  integer     err_count = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     openCnt = 0;
  integer     lat0, lat1, s, m;
  reg  [15:0] smp [0:2];

  adsq_sequencer uut (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .startEvent(startEvent), .deepSleepWake(deepSleepWake), .coreSample(coreSample),
    .sampleOpen(sampleOpen), .convRun(convRun), .inputSelActive(inputSelActive), .irq(irq)
  );

  always #4 core_clk = ~core_clk;

  // cycle ceiling against hangs, plus a tally of capacitor-open cycles
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (sampleOpen === 1'b1) openCnt = openCnt + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      summarize;
    end
  end

  task summarize;
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single AHB transfer; the request is held until hready is seen high
  task bus(input wr, input [4:0] idx, input [31:0] wd, output [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {25'h000_0000, idx, 2'h0};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task wr(input [4:0] i, input [31:0] d);
    reg [31:0] x;
    bus(1'b1, i, d, x);
  endtask

  task rdchk(input string nm, input [4:0] i, input [31:0] e);
    reg [31:0] x;
    bus(1'b0, i, 32'h0000_0000, x);
    chk(nm, x, e);
  endtask

  // polls the start bit until it drops, so a result is complete
  task waitIdle;
    reg [31:0] x;
    integer n;
    n = 0;
    do begin
      bus(1'b0, `ADSQ_IDX_TRIG, 32'h0000_0000, x);
      n = n + 1;
    end while (x[0] !== 1'b0 && n < 600);
    chk("conversion end", n < 600, 1);
  endtask

  task conv;
    wr(`ADSQ_IDX_TRIG, 32'h0000_0001);
    waitIdle;
  endtask

  // cycles from a start command to the first open capacitor
  task startLat(output integer n);
    wr(`ADSQ_IDX_TRIG, 32'h0000_0001);
    n = 0;
    while (sampleOpen !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n = n + 1;
    end
    waitIdle;
  endtask

  task waitHi(input sel);
    integer n;
    n = 0;
    while ((sel ? convRun : sampleOpen) !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n = n + 1;
    end
    chk("level reached", n < 300, 1);
  endtask

  function winExp(input [2:0] md, input [15:0] r);
    case (md)
      3'h1: winExp = r < 16'h0100;
      3'h2: winExp = r > 16'h0200;
      3'h3: winExp = r > 16'h0100 && r < 16'h0200;
      3'h4: winExp = r < 16'h0100 || r > 16'h0200;
      default: winExp = 1'b0;
    endcase
  endfunction

  task t_regs;
    for (s = 3; s < 12; s = s + 1) rdchk("reset value", s[4:0], 32'h0000_0000);
    wr(`ADSQ_IDX_WINMODE, 32'h0000_00ff);
    rdchk("window mode mask", `ADSQ_IDX_WINMODE, 32'h0000_0007);
    wr(`ADSQ_IDX_SAMPLE_LENGTH, 32'h0000_00ff);
    rdchk("sample length mask", `ADSQ_IDX_SAMPLE_LENGTH, 32'h0000_001f);
    wr(`ADSQ_IDX_INSEL, 32'h0000_00ff);
    rdchk("input select mask", `ADSQ_IDX_INSEL, 32'h0000_001f);
    wr(`ADSQ_IDX_EVENT_START_CONTROL, 32'h0000_00ff);
    rdchk("event enable mask", `ADSQ_IDX_EVENT_START_CONTROL, 32'h0000_0001);
    wr(5'h07, 32'h0000_00ff);
    rdchk("unmapped index", 5'h07, 32'h0000_0000);
    wr(`ADSQ_IDX_IRQSTAT, 32'h0000_00ff);
    rdchk("status write one idle", `ADSQ_IDX_IRQSTAT, 32'h0000_0000);
    for (s = 4; s < 10; s = s + 1) wr(s[4:0], 32'h0000_0000);
  endtask

  task t_single;
    wr(`ADSQ_IDX_CTRLA, 32'h0000_0001);
    wr(`ADSQ_IDX_IRQEN, 32'h0000_0003);
    rdchk("irq enable", `ADSQ_IDX_IRQEN, 32'h0000_0003);
    wr(`ADSQ_IDX_TRIG, 32'h0000_0001);
    rdchk("start bit busy", `ADSQ_IDX_TRIG, 32'h0000_0001);
    waitIdle;
    rdchk("result ready set", `ADSQ_IDX_IRQSTAT, 32'h0000_0001);
    @(negedge core_clk);
    chk("irq raised", irq, 1);
    wr(`ADSQ_IDX_IRQSTAT, 32'h0000_0000);
    rdchk("write zero kept", `ADSQ_IDX_IRQSTAT, 32'h0000_0001);
    wr(`ADSQ_IDX_IRQEN, 32'h0000_0002);
    repeat (2) @(negedge core_clk);
    chk("irq masked", irq, 0);
    rdchk("result value", `ADSQ_IDX_RESULT, 32'h0000_0150);
    rdchk("cleared by read", `ADSQ_IDX_IRQSTAT, 32'h0000_0000);
  endtask

  task t_window;
    smp[0] = 16'h0050;
    smp[1] = 16'h0150;
    smp[2] = 16'h0250;
    wr(`ADSQ_IDX_LOWTHR, 32'h0000_0100);
    wr(`ADSQ_IDX_HIGHTHR, 32'h0000_0200);
    for (s = 0; s < 3; s = s + 1) begin
      for (m = 0; m < 5; m = m + 1) begin
        coreSample <= smp[s][9:0];
        wr(`ADSQ_IDX_WINMODE, m);
        conv;
        rdchk("window flag", `ADSQ_IDX_IRQSTAT, {winExp(m, smp[s]), 1'b1});
        wr(`ADSQ_IDX_IRQSTAT, 32'h0000_0003);
        rdchk("write one clears", `ADSQ_IDX_IRQSTAT, 32'h0000_0000);
      end
    end
  endtask

  task t_accum;
    coreSample <= 10'h250;
    wr(`ADSQ_IDX_ACCUM, 32'h0000_0001);
    wr(`ADSQ_IDX_WINMODE, 32'h0000_0002);
    wr(`ADSQ_IDX_HIGHTHR, 32'h0000_0400);
    conv;
    rdchk("wide compare", `ADSQ_IDX_IRQSTAT, 32'h0000_0003);
    rdchk("two summed", `ADSQ_IDX_RESULT, 32'h0000_04a0);
    rdchk("match cleared by read", `ADSQ_IDX_IRQSTAT, 32'h0000_0000);
    coreSample <= 10'h3ff;
    wr(`ADSQ_IDX_ACCUM, 32'h0000_0006);
    conv;
    rdchk("sixty-four summed", `ADSQ_IDX_RESULT, 32'h0000_ffc0);
  endtask

  task t_timing;
    coreSample <= 10'h150;
    wr(`ADSQ_IDX_ACCUM, 32'h0000_0000);
    wr(`ADSQ_IDX_SAMPLE_LENGTH, 32'h0000_0003);
    openCnt = 0;
    conv;
    chk("sampling length", openCnt, 10);
    wr(`ADSQ_IDX_SAMPLE_LENGTH, 32'h0000_0000);
    wr(`ADSQ_IDX_ACCUM, 32'h0000_0001);
    wr(`ADSQ_IDX_DELAY, 32'h0000_0005);
    openCnt = 0;
    conv;
    chk("delay open time", openCnt, 18);
    rdchk("delay kept", `ADSQ_IDX_DELAY, 32'h0000_0005);
    wr(`ADSQ_IDX_ACCUM, 32'h0000_0000);
    wr(`ADSQ_IDX_DELAY, 32'h0000_001f);
    conv;
    rdchk("delay wraps", `ADSQ_IDX_DELAY, 32'h0000_0010);
    wr(`ADSQ_IDX_DELAY, 32'h0000_0000);
    startLat(lat0);
    wr(`ADSQ_IDX_DELAY, 32'h0000_0020);
    wr(`ADSQ_IDX_CTRLA, 32'h0000_0000);
    wr(`ADSQ_IDX_CTRLA, 32'h0000_0001);
    startLat(lat1);
    chk("startup 16", lat1 - lat0 >= 30 && lat1 - lat0 <= 34, 1);
    wr(`ADSQ_IDX_DELAY, 32'h0000_00a0);
    deepSleepWake <= 1'b1;
    repeat (8) @(posedge core_clk);
    deepSleepWake <= 1'b0;
    startLat(lat1);
    chk("wake startup 256", lat1 - lat0 >= 510 && lat1 - lat0 <= 514, 1);
    wr(`ADSQ_IDX_DELAY, 32'h0000_0000);
  endtask

  task t_mux_event;
    wr(`ADSQ_IDX_INSEL, 32'h0000_000a);
    conv;
    wr(`ADSQ_IDX_TRIG, 32'h0000_0001);
    wr(`ADSQ_IDX_INSEL, 32'h0000_001c);
    @(negedge core_clk);
    chk("select held", inputSelActive, 5'h0a);
    waitIdle;
    @(negedge core_clk);
    chk("select applied", inputSelActive, 5'h1c);
    rdchk("flush result", `ADSQ_IDX_RESULT, 32'h0000_0150);
    startEvent <= 1'b1;
    repeat (12) @(posedge core_clk);
    startEvent <= 1'b0;
    waitIdle;
    rdchk("event ignored", `ADSQ_IDX_IRQSTAT, 32'h0000_0000);
    wr(`ADSQ_IDX_EVENT_START_CONTROL, 32'h0000_0001);
    startEvent <= 1'b1;
    repeat (12) @(posedge core_clk);
    startEvent <= 1'b0;
    waitIdle;
    rdchk("event started", `ADSQ_IDX_IRQSTAT, 32'h0000_0001);
    wr(`ADSQ_IDX_IRQSTAT, 32'h0000_0003);
  endtask

  task t_abort_free;
    wr(`ADSQ_IDX_SAMPLE_LENGTH, 32'h0000_001f);
    wr(`ADSQ_IDX_TRIG, 32'h0000_0001);
    repeat (10) @(posedge core_clk);
    wr(`ADSQ_IDX_TRIG, 32'h0000_0000);
    rdchk("aborted idle", `ADSQ_IDX_TRIG, 32'h0000_0000);
    repeat (150) @(posedge core_clk);
    rdchk("abort no flags", `ADSQ_IDX_IRQSTAT, 32'h0000_0000);
    wr(`ADSQ_IDX_CTRLA, 32'h0000_0003);
    wr(`ADSQ_IDX_TRIG, 32'h0000_0001);
    waitHi(1'b1);
    while (convRun === 1'b1) @(negedge core_clk);
    waitHi(1'b0);
    wr(`ADSQ_IDX_CTRLA, 32'h0000_0001);
    wr(`ADSQ_IDX_TRIG, 32'h0000_0000);
    waitIdle;
    rdchk("first free result", `ADSQ_IDX_IRQSTAT, 32'h0000_0001);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_single;
    t_window;
    t_accum;
    t_timing;
    t_mux_event;
    t_abort_free;
    summarize;
  end
endmodule
